// [rtl/pmc_top.sv]
// Printer mechanism controller: carriage, feed, printhead, character intake
//
// How it works
// - A home transducer report clears the horizontal column position to zero.
// - Motion transducer pulses during carriage stepping count as proof of movement.
// - Line spacing of 6 or 8 lines per inch only changes the feed steps per line feed.
// - A move without motion is retried once, then the fault lamp lights with code 5.
// - Print-position pulses after homing track the column that decides when to fire.
// - A dot column is fired as a 9-bit code, one bit per print wire.
// - The paper feed motor only ever steps forward.
// - With no paper, the line is finished, then offline, fault lamp and code 7.
// - Key codes are handled locally offline and sent to the transmitter online.
// - A receiver's available strobe makes the controller fetch and pass on the code.
// - Codes are classified; unused control codes among the 32 are discarded.
// - Past 132 characters a line is truncated or faulted by the selected mode.
// - Codes 012, 013, 014 and 015 end the current print line.
// - Code 033 starts an escape; an invalid follower drops it and is handled normally.
// - With escapes disabled, escape codes are ignored and followers print normally.
// - The carriage drive takes a direction so it can step left or right.
`timescale 1ns/100ps
`include "pmc_defines.svh"
module pmc_top
   import pmc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic home_sense,
   input wire logic motion_pulse,
   input wire logic pos_pulse,
   input wire logic paper_present,
   input wire logic lpi8_sel,
   input wire logic overrun_fault_mode,
   input wire logic esc_disable,
   input wire logic online,
   input wire logic [7:0] stall_limit,
   input wire logic fault_reset,
   input wire logic rx_avail,
   input wire logic [6:0] rx_code,
   input wire logic key_valid,
   input wire logic [6:0] key_code,
   input wire logic move_req,
   input wire logic move_dir,
   input wire logic [7:0] move_steps,
   input wire logic fire_req,
   input wire logic [7:0] fire_column,
   input wire logic [8:0] fire_pattern,
   output logic rx_fetch,
   output logic char_valid,
   output logic [6:0] char_code,
   output logic [1:0] char_class,
   output logic tx_load,
   output logic [6:0] tx_code,
   output logic car_step,
   output logic car_dir,
   output logic feed_step,
   output logic feed_fwd,
   output logic [8:0] wire_fire,
   output logic [7:0] column,
   output logic fault_lamp,
   output logic [3:0] fault_code,
   output logic offline_force,
   output logic busy
);
   pmc_state_t state_q;
   logic [7:0] steps_left_q;
   logic [7:0] steps_quiet_q;
   logic [1:0] tries_q;
   logic [7:0] feed_left_q;
   logic [7:0] line_cnt_q;
   logic esc_q;
   logic paper_lost_q;
   logic line_open_q;
   logic fire_done_q;

   // Classification of one 7-bit code against the escape state
   function automatic pmc_class_t classify(input logic [6:0] c, input logic esc);
      if (esc && c >= `PMC_ESC_LO && c <= `PMC_ESC_HI) begin
         classify = PMC_CLS_DROP; // Consumed as escape function
      end else if (c == `PMC_CODE_NL || c == `PMC_CODE_VT || c == `PMC_CODE_FF ||
                   c == `PMC_CODE_CR) begin
         classify = PMC_CLS_TERM;
      end else if (c == `PMC_CODE_ESC) begin
         classify = PMC_CLS_ESC;
      end else if (c < `PMC_CTRL_TOP || c == `PMC_CODE_DEL) begin
         classify = PMC_CLS_DROP;
      end else begin
         classify = PMC_CLS_PRINT;
      end
   endfunction

   // Incoming code path: receiver or local key
   logic in_valid;
   logic [6:0] in_code;
   pmc_class_t in_cls;
   always_comb begin
      in_valid = (rx_avail && !rx_fetch) || (key_valid && !online);
      in_code = (rx_avail && !rx_fetch) ? rx_code : key_code;
      in_cls = classify(in_code, esc_q);
   end

   // Receiver fetch strobe, one cycle per available code
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rx_fetch <= 1'b0;
      end else begin
         rx_fetch <= rx_avail && !rx_fetch;
      end
   end
   // Key codes go to the transmitter while online
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tx_load <= 1'b0;
         tx_code <= 7'h00;
      end else begin
         tx_load <= key_valid && online;
         tx_code <= (key_valid && online) ? key_code : tx_code;
      end
   end
   // Escape tracking; an invalid follower falls through as normal
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         esc_q <= 1'b0;
      end else if (in_valid) begin
         esc_q <= (in_cls == PMC_CLS_ESC) && !esc_disable;
      end
   end
   // Character output with line length limit
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         char_valid <= 1'b0;
         char_code <= 7'h00;
         char_class <= PMC_CLS_PRINT;
         line_cnt_q <= `PMC_POS_ZERO;
      end else begin
         char_valid <= 1'b0;
         if (in_valid) begin
            char_code <= in_code;
            char_class <= in_cls;
            if (in_cls == PMC_CLS_TERM) begin
               line_cnt_q <= `PMC_POS_ZERO;
               char_valid <= 1'b1;
            end else if (in_cls == PMC_CLS_PRINT) begin
               if (line_cnt_q < `PMC_LINE_MAX) begin
                  line_cnt_q <= line_cnt_q + 8'h01;
                  char_valid <= 1'b1;
               end // truncate or fault past limit
            end // Escape and dropped codes print nothing
         end
      end
   end
   // Line open tracking for paper-out handling
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         line_open_q <= 1'b0;
      end else if (in_valid && in_cls == PMC_CLS_TERM) begin
         line_open_q <= 1'b0;
      end else if (in_valid && in_cls == PMC_CLS_PRINT) begin
         line_open_q <= 1'b1;
      end
   end

   // Paper-out is latched, acted on at end of line
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         paper_lost_q <= 1'b0;
      end else if (!paper_present) begin
         paper_lost_q <= 1'b1;
      end else if (fault_reset) begin
         paper_lost_q <= 1'b0;
      end
   end
   // Mechanism sequencer: move, fire, feed
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_q <= PMC_IDLE;
         steps_left_q <= 8'h00;
         steps_quiet_q <= 8'h00;
         tries_q <= 2'h0;
         feed_left_q <= 8'h00;
         car_step <= 1'b0;
         car_dir <= 1'b0;
         feed_step <= 1'b0;
         wire_fire <= 9'h000;
         busy <= 1'b0;
         fire_done_q <= 1'b0;
         feed_fwd <= 1'b1; // forward only, never changed
      end else begin
         car_step <= 1'b0;
         feed_step <= 1'b0;
         wire_fire <= 9'h000;
         fire_done_q <= fire_done_q && fire_req; // One firing per held request
         case (state_q)
            PMC_IDLE: begin
               busy <= 1'b0;
               if (fault_lamp) begin
                  state_q <= PMC_HALT;
               end else if (in_valid && in_cls == PMC_CLS_TERM && in_code != `PMC_CODE_CR) begin
                  feed_left_q <= lpi8_sel ? `PMC_STEPS_8LPI : `PMC_STEPS_6LPI;
                  state_q <= PMC_FEED;
                  busy <= 1'b1;
               end else if (move_req && move_steps != 8'h00) begin
                  car_dir <= move_dir;
                  steps_left_q <= move_steps;
                  steps_quiet_q <= 8'h00;
                  tries_q <= 2'h1;
                  state_q <= PMC_MOVE;
                  busy <= 1'b1;
               end else if (fire_req && !fire_done_q) begin
                  state_q <= PMC_FIRE;
                  busy <= 1'b1;
               end
            end
            PMC_MOVE: begin
               if (motion_pulse) begin
                  steps_quiet_q <= 8'h00;
               end else if (car_step) begin
                  steps_quiet_q <= steps_quiet_q + 8'h01;
               end
               if (!motion_pulse && steps_quiet_q >= stall_limit) begin
                  steps_quiet_q <= 8'h00;
                  if (tries_q < `PMC_MAX_TRIES) begin
                     tries_q <= tries_q + 2'h1; // retry once
                     steps_left_q <= move_steps;
                  end else begin
                     state_q <= PMC_HALT;
                  end
               end else if (steps_left_q == 8'h00) begin
                  state_q <= PMC_IDLE;
               end else if (!car_step) begin
                  car_step <= 1'b1;
                  steps_left_q <= steps_left_q - 8'h01;
               end
            end
            PMC_FIRE: begin
               if (column == fire_column) begin
                  wire_fire <= fire_pattern;
                  fire_done_q <= 1'b1;
                  state_q <= PMC_IDLE;
               end else if (!fire_req) begin
                  state_q <= PMC_IDLE;
               end
            end
            PMC_FEED: begin
               if (feed_left_q == 8'h00) begin
                  state_q <= PMC_IDLE;
               end else if (!feed_step) begin
                  feed_step <= 1'b1;
                  feed_left_q <= feed_left_q - 8'h01;
               end
            end
            PMC_HALT: begin
               busy <= 1'b0;
               if (fault_reset && paper_present) begin
                  state_q <= PMC_IDLE;
               end
            end
            default: begin
               state_q <= PMC_IDLE;
            end
         endcase
      end
   end
   // Column tracking from home and print-position pulses
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         column <= `PMC_POS_ZERO;
      end else if (home_sense) begin
         column <= `PMC_POS_ZERO;
      end else if (pos_pulse) begin
         column <= car_dir ? column - 8'h01 : column + 8'h01;
      end
   end

   // Fault lamp, code and forced offline
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         fault_lamp <= 1'b0;
         fault_code <= `PMC_FAULT_NONE;
         offline_force <= 1'b0;
      end else if (state_q == PMC_MOVE && !motion_pulse && steps_quiet_q >= stall_limit &&
                   tries_q >= `PMC_MAX_TRIES) begin
         fault_lamp <= 1'b1;
         fault_code <= `PMC_FAULT_STALL;
      end else if (paper_lost_q && !line_open_q && !offline_force) begin
         fault_lamp <= 1'b1;
         fault_code <= `PMC_FAULT_FORMS;
         offline_force <= 1'b1;
      end else if (in_valid && in_cls == PMC_CLS_PRINT && overrun_fault_mode &&
                   line_cnt_q >= `PMC_LINE_MAX) begin
         fault_lamp <= 1'b1;
         fault_code <= `PMC_FAULT_OVER;
      end else if (fault_reset) begin
         fault_lamp <= 1'b0;
         fault_code <= `PMC_FAULT_NONE;
         offline_force <= 1'b0;
      end
   end
endmodule

// [include/pmc_defines.svh]
// Constants for the printer mechanism controller
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
`define PMC_FAULT_NONE 4'h0
`define PMC_FAULT_STALL 4'h5
`define PMC_FAULT_FORMS 4'h7
`define PMC_FAULT_OVER 4'h9
`define PMC_LINE_MAX 8'h84
`define PMC_STEPS_6LPI 8'h0C
`define PMC_STEPS_8LPI 8'h09
`define PMC_CODE_NL 7'h0A
`define PMC_CODE_VT 7'h0B
`define PMC_CODE_FF 7'h0C
`define PMC_CODE_CR 7'h0D
`define PMC_CODE_ESC 7'h1B
`define PMC_CODE_DEL 7'h7F
`define PMC_CTRL_TOP 7'h20
`define PMC_ESC_LO 7'h40
`define PMC_ESC_HI 7'h5F
`define PMC_MAX_TRIES 2'h2
`define PMC_POS_ZERO 8'h00
`endif

// [include/pmc_pkg.sv]
// Types for the printer mechanism controller
package pmc_pkg;
   typedef enum logic [4:0] {
      PMC_IDLE = 5'b00001,
      PMC_MOVE = 5'b00010,
      PMC_FIRE = 5'b00100,
      PMC_FEED = 5'b01000,
      PMC_HALT = 5'b10000
   } pmc_state_t;
   typedef enum logic [1:0] {
      PMC_CLS_PRINT = 2'h0,
      PMC_CLS_TERM = 2'h1,
      PMC_CLS_ESC = 2'h2,
      PMC_CLS_DROP = 2'h3
   } pmc_class_t;
endpackage

// [test/pmc_monitor.sv]
// Port checker for the printer mechanism controller
`timescale 1ns/100ps
`include "pmc_defines.svh"
module pmc_monitor
   import pmc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic home_sense,
   input wire logic pos_pulse,
   input wire logic car_dir,
   input wire logic online,
   input wire logic key_valid,
   input wire logic [6:0] key_code,
   input wire logic rx_avail,
   input wire logic fire_req,
   input wire logic [8:0] fire_pattern,
   input wire logic rx_fetch,
   input wire logic char_valid,
   input wire logic [1:0] char_class,
   input wire logic tx_load,
   input wire logic [6:0] tx_code,
   input wire logic feed_fwd,
   input wire logic [8:0] wire_fire,
   input wire logic [7:0] column,
   input wire logic fault_lamp,
   input wire logic [3:0] fault_code,
   input wire logic offline_force
);
   // One clock domain, all checks idle in reset
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   feed_fwd_a: assert property (feed_fwd)
      else $error("paper feed not forward");
   home_clear_a: assert property (home_sense && !pos_pulse |=> column == 8'h00)
      else $error("home did not clear column");
   column_step_a: assert property (pos_pulse && !home_sense && !car_dir |=>
      column == $past(column) + 8'h01) else $error("column did not count");
   fetch_cause_a: assert property ($rose(rx_fetch) |-> $past(rx_avail))
      else $error("fetch without available code");
   key_tx_a: assert property (key_valid && online |=> tx_load &&
      tx_code == $past(key_code)) else $error("online key not sent");
   char_class_a: assert property (char_valid |->
      char_class inside {PMC_CLS_PRINT, PMC_CLS_TERM}) else $error("bad class");
   fire_cause_a: assert property (wire_fire != 9'h000 |-> $past(fire_req) &&
      wire_fire == $past(fire_pattern)) else $error("wrong firing code");
   fault_code_a: assert property (fault_lamp |-> fault_code inside
      {`PMC_FAULT_STALL, `PMC_FAULT_FORMS, `PMC_FAULT_OVER}) else $error("bad fault");
   paper_off_a: assert property (fault_code == `PMC_FAULT_FORMS |-> offline_force)
      else $error("paper fault left online");
   // Main scenarios reached
   cover property (char_valid && char_class == PMC_CLS_TERM);
   cover property (fault_code == `PMC_FAULT_STALL);
   cover property (wire_fire != 9'h000);
endmodule
bind pmc_top pmc_monitor i_pmc_monitor (.*);

// [test/pmc_mech_model.sv]
// Behavioural carriage transducers of the mechanism
`timescale 1ns/100ps
module pmc_mech_model (
   input wire logic sys_clk,
   input wire logic car_step,
   input wire logic car_dir,
   input wire logic stall,
   output logic motion_pulse,
   output logic pos_pulse,
   output logic home_sense
);
   logic [7:0] pos_q;
   // Carriage starts parked at the left margin
   initial begin
      pos_q = 8'h00;
      motion_pulse = 1'b0;
      pos_pulse = 1'b0;
   end
   // Slot and position pulses follow each step unless stalled
   always @(posedge sys_clk) begin
      motion_pulse <= car_step && !stall;
      pos_pulse <= car_step && !stall;
      if (car_step && !stall)
         pos_q <= car_dir ? pos_q - 8'h01 : pos_q + 8'h01;
   end
   assign home_sense = (pos_q == 8'h00);
endmodule

// [test/pmc_top_tb.sv]
// Self-checking bench for the printer mechanism controller
`timescale 1ns/100ps
`include "pmc_defines.svh"
module pmc_top_tb;
   logic sys_clk = 1'b0, rst_n = 1'b0, paper_present = 1'b1, lpi8_sel = 1'b0, stall = 1'b0;
   logic overrun_fault_mode = 1'b0, esc_disable = 1'b0, online = 1'b0, fault_reset = 1'b0;
   logic rx_avail = 1'b0, key_valid = 1'b0, move_req = 1'b0, move_dir = 1'b0, fire_req = 1'b0;
   logic [6:0] rx_code = 7'h00, key_code = 7'h00;
   logic [7:0] stall_limit = 8'h03, move_steps = 8'h00, fire_column = 8'h00;
   logic [8:0] fire_pattern = 9'h000, last_cv = 9'h000, last_tx = 9'h000, last_fire = 9'h000;
   wire logic home_sense, motion_pulse, pos_pulse, rx_fetch, char_valid, tx_load, car_step;
   wire logic car_dir, feed_step, feed_fwd, fault_lamp, offline_force, busy;
   wire logic [6:0] char_code, tx_code;
   wire logic [1:0] char_class;
   wire logic [8:0] wire_fire;
   wire logic [7:0] column;
   wire logic [3:0] fault_code;
   int n_mismatch = 0, total_checks = 0, n_cv = 0, n_tx = 0, n_feed = 0, n_step = 0, i;
   pmc_top i_pmc_top (.*);
   pmc_mech_model i_pmc_mech_model (.*);
   always #12.5 sys_clk = ~sys_clk;
   // Tally design events in the settled half cycle
   always @(negedge sys_clk) begin
      if (char_valid === 1'b1) begin
         n_cv++;
         last_cv = {char_class, char_code};
      end
      if (tx_load === 1'b1) begin
         n_tx++;
         last_tx = {2'h0, tx_code};
      end
      if (feed_step === 1'b1) n_feed++;
      if (car_step === 1'b1) n_step++;
      if (wire_fire !== 9'h000) last_fire = wire_fire;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Bounded wait: 0 idle, 1 fetch, 2 fault, 3 firing
   task automatic wait_on(input int sel);
      int k;
      for (k = 0; k < 2000; k++) begin
         @(negedge sys_clk);
         if (sel == 0 ? busy === 1'b0 : sel == 1 ? rx_fetch === 1'b1 :
             sel == 2 ? fault_lamp === 1'b1 : wire_fire !== 9'h000) break;
      end
      if (k == 2000) begin
         n_mismatch++;
         give_verdict();
      end
   endtask
   task automatic send_rx(input logic [6:0] c);
      @(posedge sys_clk);
      rx_avail <= 1'b1;
      rx_code <= c;
      wait_on(1);
      @(posedge sys_clk);
      rx_avail <= 1'b0;
   endtask
   task automatic press(input logic [6:0] c);
      @(posedge sys_clk);
      key_valid <= 1'b1;
      key_code <= c;
      @(posedge sys_clk);
      key_valid <= 1'b0;
      repeat (3) @(negedge sys_clk);
   endtask
   task automatic run_move(input logic d, input logic [7:0] n, input int sel);
      @(posedge sys_clk);
      move_req <= 1'b1;
      move_dir <= d;
      move_steps <= n;
      @(posedge sys_clk);
      move_req <= 1'b0;
      @(negedge sys_clk);
      wait_on(sel);
      repeat (2) @(negedge sys_clk);
   endtask
   task automatic pulse_reset;
      @(posedge sys_clk);
      fault_reset <= 1'b1;
      @(posedge sys_clk);
      fault_reset <= 1'b0;
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(negedge sys_clk);
      chk({feed_fwd, fault_code, column}, 13'h1000);
      for (i = 0; i < 5; i++) begin
         n_cv = 0;
         @(posedge sys_clk);
         esc_disable <= (i == 4);
         send_rx(i < 2 ? (i == 0 ? 7'h41 : 7'h01) : 7'h1B);
         if (i > 1) send_rx(i == 3 ? 7'h7A : 7'h41);
         repeat (3) @(negedge sys_clk);
         chk(n_cv, (i == 1 || i == 2) ? 0 : 1);
         if (n_cv == 1) chk(last_cv, {2'h0, i == 3 ? 7'h7A : 7'h41});
      end
      // Terminators close lines; all but return feed forward
      for (i = 0; i < 4; i++) begin
         n_feed = 0;
         @(posedge sys_clk);
         lpi8_sel <= i[0];
         send_rx(7'h0A + i[6:0]);
         repeat (40) @(negedge sys_clk);
         chk(n_feed, i == 3 ? 0 : i[0] ? 9 : 12);
         chk(last_cv, {2'h1, 7'h0A + i[6:0]});
      end
      n_cv = 0;
      press(7'h42);
      @(posedge sys_clk);
      online <= 1'b1;
      press(7'h43);
      chk(n_cv, 1);
      chk(n_tx, 1);
      chk({last_cv, last_tx}, {9'h042, 9'h043});
      // Over-long lines: truncated, then faulted
      for (i = 0; i < 2; i++) begin
         send_rx(7'h0D);
         n_cv = 0;
         @(posedge sys_clk);
         overrun_fault_mode <= i[0];
         repeat (133) send_rx(7'h41);
         repeat (3) @(negedge sys_clk);
         chk(n_cv, 132);
         chk(fault_code, i[0] ? `PMC_FAULT_OVER : `PMC_FAULT_NONE);
      end
      pulse_reset();
      send_rx(7'h0D);
      run_move(1'b0, 8'h02, 0);
      chk({car_dir, column}, 9'h002);
      chk(n_step, 2);
      @(posedge sys_clk);
      fire_req <= 1'b1;
      fire_column <= 8'h02;
      fire_pattern <= 9'h1A5;
      wait_on(3);
      @(posedge sys_clk);
      fire_req <= 1'b0;
      chk(last_fire, 9'h1A5);
      run_move(1'b1, 8'h02, 0);
      chk({car_dir, column}, 9'h100);
      @(posedge sys_clk);
      stall <= 1'b1;
      n_step = 0;
      run_move(1'b0, 8'h20, 2);
      chk(fault_code, `PMC_FAULT_STALL);
      chk(n_step, 6);
      @(posedge sys_clk);
      stall <= 1'b0;
      paper_present <= 1'b0;
      pulse_reset();
      wait_on(2);
      chk({offline_force, fault_code}, 5'h17);
      @(posedge sys_clk);
      paper_present <= 1'b1;
      pulse_reset();
      repeat (2) @(negedge sys_clk);
      chk({fault_lamp, fault_code}, 5'h00);
      give_verdict();
   end
endmodule
